// [logic/ufc_ep_decode.sv]
/*
  Endpoint decode: turns the sixteen endpoint control bytes into permissions
  for the transaction engine. Purely combinational, same clock domain.
*/
module ufc_ep_decode (
  ufc_ep_if.dec ep
);
  import ufc_pkg::*;

  always_comb begin
    for (int i = 0; i < NUM_ENDPOINTS; i++) begin
      ep.rx_allowed[i]    = ep.ep_ctrl[i][EP_RX_ENABLE]; // R15
      ep.tx_allowed[i]    = ep.ep_ctrl[i][EP_TX_ENABLE]; // R15
      // Control bit only counts when both directions are on
      ep.setup_allowed[i] = ep.ep_ctrl[i][EP_RX_ENABLE] & ep.ep_ctrl[i][EP_TX_ENABLE]
                            & ~ep.ep_ctrl[i][EP_CTRL_DISABLE]; // R14
      ep.handshake_on[i]  = ep.ep_ctrl[i][EP_HANDSHAKE]; // R17
    end
    // Host-only fields live in endpoint 0 only
    ep.ls_direct = ep.host_mode & ep.ep_ctrl[0][EP_LOW_SPEED]; // R12 R19 R20
    ep.nak_retry = ep.host_mode & ~ep.ep_ctrl[0][EP_RETRY_DISABLE]; // R13 R19
  end
endmodule

// [logic/ufc_ep_if.sv]
/*
  Interface carrying the endpoint control bytes between the register file
  and the endpoint decode module. Assumes a single clock domain.
*/
interface ufc_ep_if;
  logic [7:0] ep_ctrl [16];
  logic       host_mode;
  logic [15:0] rx_allowed;
  logic [15:0] tx_allowed;
  logic [15:0] setup_allowed;
  logic [15:0] handshake_on;
  logic        ls_direct;
  logic        nak_retry;
  modport regs (output ep_ctrl, output host_mode, input rx_allowed, input tx_allowed,
                input setup_allowed, input handshake_on, input ls_direct, input nak_retry);
  modport dec  (input ep_ctrl, input host_mode, output rx_allowed, output tx_allowed,
                output setup_allowed, output handshake_on, output ls_direct,
                output nak_retry);
endinterface

// [logic/ufc_pkg.sv]
/*
  Package for the frame, descriptor table and endpoint configuration block:
  register offsets, field positions and reset values.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package ufc_pkg;
  localparam logic [7:0] OFF_FRAME_NUMBER_LOW  = 8'h00;
  localparam logic [7:0] OFF_SOF_THRESHOLD     = 8'h04;
  localparam logic [7:0] OFF_TABLE_PAGE_LOW    = 8'h08;
  localparam logic [7:0] OFF_TABLE_PAGE_MID    = 8'h0C;
  localparam logic [7:0] OFF_TABLE_PAGE_HIGH   = 8'h10;
  localparam logic [7:0] OFF_MODULE_CONFIG     = 8'h14;
  localparam logic [7:0] OFF_MODE_CONTROL      = 8'h18;
  localparam logic [7:0] OFF_ENDPOINT_BASE     = 8'h40;
  localparam int         NUM_ENDPOINTS         = 16;
  localparam logic [7:0] RESET_VALUE           = 8'h00;
  // Module configuration bit positions
  localparam int CFG_EYE_TEST      = 7;
  localparam int CFG_OE_MONITOR    = 6;
  localparam int CFG_STOP_IN_IDLE  = 4;
  localparam int CFG_AUTO_SUSPEND  = 0;
  localparam logic [7:0] CFG_MASK  = 8'hD1;
  // Mode control register (host enable, software suspend)
  localparam int MODE_HOST_ENABLE  = 0;
  localparam int MODE_SW_SUSPEND   = 1;
  localparam logic [7:0] MODE_MASK = 8'h03;
  // Endpoint control bit positions
  localparam int EP_LOW_SPEED      = 7;
  localparam int EP_RETRY_DISABLE  = 6;
  localparam int EP_CTRL_DISABLE   = 4;
  localparam int EP_RX_ENABLE      = 3;
  localparam int EP_TX_ENABLE      = 2;
  localparam int EP_STALLED        = 1;
  localparam int EP_HANDSHAKE      = 0;
  localparam logic [7:0] EP_MASK   = 8'hDF;
  localparam logic [7:0] PAGE_LOW_MASK = 8'hFE;
  localparam logic [8:0] TABLE_ALIGN_ZERO = 9'h000;
endpackage

// [logic/ufc_top.sv]
/*
  Frame number, start-of-frame threshold, descriptor table base, module
  configuration and endpoint control registers behind an APB slave.
  Assumes the transaction engine supplies the start-of-frame strobe and
  frame number on pclk, and the power controller supplies idle/sleep levels.
*/
// The implementer's own choices: the APB register port and the address map.
// How it works
// R1: Store low frame bits on each SOF
// R2: Software picks threshold by packet size
// R3: Low page holds base bits 15:9
// R4: Mid page holds base bits 23:16
// R5: High page holds base bits 31:24
// R6: Base has low nine bits zero
// R7: Eye test runs while its bit set
// R8: Active-low OE shown only when monitored
// R9: Stop in idle halts module when set
// R10: Auto suspend on sleep entry
// R11: Otherwise only software suspend stops clock
// R12: Endpoint 0 low-speed direct in host
// R13: Endpoint 0 NAK retry unless disabled
// R14: Control disable blocks SETUP when bidirectional
// R15: Receive and transmit follow enable bits
// R16: Stall bit readable and writable
// R17: Handshakes sent only when enabled
// R18: Unimplemented bits read zero
// R19: Host fields act only in host mode
// R20: Sixteen endpoint registers, host fields EP0
module ufc_top (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         sof_received,
  input  wire logic [10:0]  sof_frame_number,
  input  wire logic         idle_mode,
  input  wire logic         sleep_mode,
  input  wire logic         driving_lines,
  input  wire logic         stall_event,
  input  wire logic [3:0]   stall_endpoint,
  output logic      [31:0]  table_base_address,
  output logic              eye_pattern_test_active,
  output logic              output_enable_n,
  output logic              module_halted,
  output logic              module_suspended,
  output logic      [15:0]  rx_allowed,
  output logic      [15:0]  tx_allowed,
  output logic      [15:0]  setup_allowed,
  output logic      [15:0]  handshake_on,
  output logic              low_speed_direct,
  output logic              nak_retry_enabled
);
  import ufc_pkg::*;

  // ******************************************
  // Registers
  // ******************************************
  logic [7:0] frame_number_low_bits;
  logic [7:0] sof_threshold_value;
  logic [7:0] table_base_bits_low;
  logic [7:0] table_base_bits_mid;
  logic [7:0] table_base_bits_high;
  logic [7:0] module_configuration;
  logic [7:0] mode_control;
  logic [7:0] endpoint_control [NUM_ENDPOINTS];
  logic [7:0] next_frame_number_low_bits;
  logic [7:0] next_sof_threshold_value;
  logic [7:0] next_table_base_bits_low;
  logic [7:0] next_table_base_bits_mid;
  logic [7:0] next_table_base_bits_high;
  logic [7:0] next_module_configuration;
  logic [7:0] next_mode_control;
  logic [7:0] next_endpoint_control [NUM_ENDPOINTS];
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_en;
  logic        rd_en;
  logic        ep_hit;
  logic [3:0]  ep_index;
  logic        known;

  ufc_ep_if ep ();

  // ******************************************
  // Address decode
  // ******************************************
  // Single-cycle access: pready stays high, so each access ends in its
  // first access-phase cycle.
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & ~penable & ~pwrite;
  assign ep_hit = (paddr[7:6] == OFF_ENDPOINT_BASE[7:6]);
  assign ep_index = paddr[5:2];

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[7:6] == OFF_ENDPOINT_BASE[7:6] && a[1:0] == 2'h0)
        || a == OFF_FRAME_NUMBER_LOW || a == OFF_SOF_THRESHOLD
        || a == OFF_TABLE_PAGE_LOW || a == OFF_TABLE_PAGE_MID
        || a == OFF_TABLE_PAGE_HIGH || a == OFF_MODULE_CONFIG
        || a == OFF_MODE_CONTROL;
  endfunction

  assign known = is_mapped(paddr);

  // ******************************************
  // Next-state logic
  // ******************************************
  always_comb begin
    next_frame_number_low_bits = frame_number_low_bits;
    next_sof_threshold_value   = sof_threshold_value;
    next_table_base_bits_low   = table_base_bits_low;
    next_table_base_bits_mid   = table_base_bits_mid;
    next_table_base_bits_high  = table_base_bits_high;
    next_module_configuration  = module_configuration;
    next_mode_control          = mode_control;
    for (int i = 0; i < NUM_ENDPOINTS; i++) begin
      next_endpoint_control[i] = endpoint_control[i];
    end
    if (sof_received) begin
      next_frame_number_low_bits = sof_frame_number[7:0]; // R1
    end
    if (wr_en && known) begin
      unique case (paddr)
        OFF_SOF_THRESHOLD:   next_sof_threshold_value = pwdata[7:0]; // R2
        OFF_TABLE_PAGE_LOW:  next_table_base_bits_low = pwdata[7:0] & PAGE_LOW_MASK; // R3 R18
        OFF_TABLE_PAGE_MID:  next_table_base_bits_mid = pwdata[7:0]; // R4
        OFF_TABLE_PAGE_HIGH: next_table_base_bits_high = pwdata[7:0]; // R5
        OFF_MODULE_CONFIG:   next_module_configuration = pwdata[7:0] & CFG_MASK; // R18
        OFF_MODE_CONTROL:    next_mode_control = pwdata[7:0] & MODE_MASK;
        default: begin
          if (ep_hit) begin
            next_endpoint_control[ep_index] = pwdata[7:0] & EP_MASK; // R16 R18 R20
          end
        end
      endcase
    end
    // Hardware stall event wins over a software write in the same cycle
    if (stall_event) begin
      next_endpoint_control[stall_endpoint][EP_STALLED] = 1'b1; // R16
    end
  end

  // Read data is captured in the setup cycle so it is registered output
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (rd_en) begin
      next_prdata = 32'h0000_0000; // R18
      if (!known) begin
        next_pslverr = 1'b1;
      end else if (ep_hit) begin
        next_prdata[7:0] = endpoint_control[ep_index];
      end else begin
        unique case (paddr)
          OFF_FRAME_NUMBER_LOW: next_prdata[7:0] = frame_number_low_bits;
          OFF_SOF_THRESHOLD:    next_prdata[7:0] = sof_threshold_value;
          OFF_TABLE_PAGE_LOW:   next_prdata[7:0] = table_base_bits_low;
          OFF_TABLE_PAGE_MID:   next_prdata[7:0] = table_base_bits_mid;
          OFF_TABLE_PAGE_HIGH:  next_prdata[7:0] = table_base_bits_high;
          OFF_MODULE_CONFIG:    next_prdata[7:0] = module_configuration;
          default:              next_prdata[7:0] = mode_control;
        endcase
      end
    end else if (psel && !penable && pwrite) begin
      next_pslverr = ~known;
    end else if (psel && penable) begin
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_number_low_bits <= RESET_VALUE;
      sof_threshold_value   <= RESET_VALUE;
      table_base_bits_low   <= RESET_VALUE;
      table_base_bits_mid   <= RESET_VALUE;
      table_base_bits_high  <= RESET_VALUE;
      module_configuration  <= RESET_VALUE;
      mode_control          <= RESET_VALUE;
      for (int i = 0; i < NUM_ENDPOINTS; i++) begin
        endpoint_control[i] <= RESET_VALUE;
      end
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      frame_number_low_bits <= next_frame_number_low_bits;
      sof_threshold_value   <= next_sof_threshold_value;
      table_base_bits_low   <= next_table_base_bits_low;
      table_base_bits_mid   <= next_table_base_bits_mid;
      table_base_bits_high  <= next_table_base_bits_high;
      module_configuration  <= next_module_configuration;
      mode_control          <= next_mode_control;
      for (int i = 0; i < NUM_ENDPOINTS; i++) begin
        endpoint_control[i] <= next_endpoint_control[i];
      end
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ******************************************
  // Configuration outputs
  // ******************************************
  logic [31:0] next_table_base;
  logic        next_eye;
  logic        next_oe_n;
  logic        next_halted;
  logic        next_suspended;

  always_comb begin
    next_table_base = {table_base_bits_high, table_base_bits_mid,
                       table_base_bits_low[7:1], TABLE_ALIGN_ZERO}; // R3 R4 R5 R6
    next_eye        = module_configuration[CFG_EYE_TEST]; // R7
    // Indication is active low and only shown while monitoring is on
    next_oe_n       = ~(module_configuration[CFG_OE_MONITOR] & driving_lines); // R8
    next_halted     = idle_mode & module_configuration[CFG_STOP_IN_IDLE]; // R9
    next_suspended  = mode_control[MODE_SW_SUSPEND]
                    | (sleep_mode & module_configuration[CFG_AUTO_SUSPEND]); // R10 R11
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_base_address      <= 32'h0000_0000;
      eye_pattern_test_active <= 1'b0;
      output_enable_n         <= 1'b1;
      module_halted           <= 1'b0;
      module_suspended        <= 1'b0;
    end else begin
      table_base_address      <= next_table_base;
      eye_pattern_test_active <= next_eye;
      output_enable_n         <= next_oe_n;
      module_halted           <= next_halted;
      module_suspended        <= next_suspended;
    end
  end

  // ******************************************
  // Endpoint decode
  // ******************************************
  always_comb begin
    for (int i = 0; i < NUM_ENDPOINTS; i++) begin
      ep.ep_ctrl[i] = endpoint_control[i];
    end
    ep.host_mode = mode_control[MODE_HOST_ENABLE]; // R19
  end

  ufc_ep_decode u_decode (
    .ep (ep.dec)
  );

  assign rx_allowed        = ep.rx_allowed;
  assign tx_allowed        = ep.tx_allowed;
  assign setup_allowed     = ep.setup_allowed;
  assign handshake_on      = ep.handshake_on;
  assign low_speed_direct  = ep.ls_direct;
  assign nak_retry_enabled = ep.nak_retry;

  // ******************************************
  // Checks
  // ******************************************
  sequence s_sof;
    sof_received;
  endsequence

  AST_FRAME_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn) // R1
    s_sof |=> frame_number_low_bits == $past(sof_frame_number[7:0]))
    else $error("frame low bits not captured");

  AST_BASE_ALIGN: assert property (@(posedge pclk) disable iff (!presetn) // R6
    table_base_address[8:0] == 9'h000)
    else $error("table base not aligned");

  AST_BASE_TRACK: assert property (@(posedge pclk) disable iff (!presetn) // R4
    ##1 table_base_address[23:16] == $past(table_base_bits_mid))
    else $error("table base mid bits wrong");

  AST_OE_MONITOR: assert property (@(posedge pclk) disable iff (!presetn) // R8
    !module_configuration[CFG_OE_MONITOR] ##1 !module_configuration[CFG_OE_MONITOR]
      |-> output_enable_n)
    else $error("oe indication active while unmonitored");

  AST_IDLE_STOP: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (idle_mode && module_configuration[CFG_STOP_IN_IDLE]) |=> module_halted)
    else $error("module not halted in idle");

  AST_NO_AUTO_SUSPEND: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (!module_configuration[CFG_AUTO_SUSPEND] && !mode_control[MODE_SW_SUSPEND])
      |=> !module_suspended)
    else $error("suspended without request");

  AST_HOST_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // R19
    !mode_control[MODE_HOST_ENABLE] |-> (!low_speed_direct && !nak_retry_enabled))
    else $error("host field active in device mode");

  AST_SETUP_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R14
    setup_allowed[0] |-> (rx_allowed[0] && tx_allowed[0]
                          && !endpoint_control[0][EP_CTRL_DISABLE]))
    else $error("setup allowed wrongly");

  AST_STALL_SET: assert property (@(posedge pclk) disable iff (!presetn) // R16
    stall_event |=> endpoint_control[$past(stall_endpoint)][EP_STALLED])
    else $error("stall not recorded");

  AST_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R18
    prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  sequence s_frame_write;
    psel && penable && pwrite && paddr == OFF_FRAME_NUMBER_LOW && !sof_received;
  endsequence

  sequence s_bad_read;
    psel && !penable && !pwrite && !known;
  endsequence

  AST_FRAME_READ_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // R1
    s_frame_write |=> $stable(frame_number_low_bits))
    else $error("frame low bits written by software");

  AST_BASE_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R3
    ##1 table_base_address[15:9] == $past(table_base_bits_low[7:1]) && !table_base_bits_low[0])
    else $error("table base low page wrong");

  AST_BASE_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // R5
    ##1 table_base_address[31:24] == $past(table_base_bits_high))
    else $error("table base high bits wrong");

  AST_EYE_TEST: assert property (@(posedge pclk) disable iff (!presetn) // R7
    ##1 eye_pattern_test_active == $past(module_configuration[CFG_EYE_TEST]))
    else $error("eye test enable not followed");

  AST_AUTO_SUSPEND: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (sleep_mode && module_configuration[CFG_AUTO_SUSPEND]) |=> module_suspended)
    else $error("no automatic suspend on sleep");

  AST_LS_DIRECT: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (mode_control[MODE_HOST_ENABLE] && endpoint_control[0][EP_LOW_SPEED]) |-> low_speed_direct)
    else $error("low-speed direct not enabled");

  AST_NAK_RETRY: assert property (@(posedge pclk) disable iff (!presetn) // R13
    mode_control[MODE_HOST_ENABLE]
      |-> (nak_retry_enabled == !endpoint_control[0][EP_RETRY_DISABLE]))
    else $error("retry control not followed");

  AST_EP_ENABLES: assert property (@(posedge pclk) disable iff (!presetn) // R15 R17 R20
    rx_allowed[15] == endpoint_control[15][EP_RX_ENABLE]
      && tx_allowed[15] == endpoint_control[15][EP_TX_ENABLE]
      && handshake_on[15] == endpoint_control[15][EP_HANDSHAKE])
    else $error("endpoint enables not followed");

  AST_BAD_READ: assert property (@(posedge pclk) disable iff (!presetn) // R18
    s_bad_read |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped read not refused");
endmodule

// [tb/ufc_bus_partner.sv]
/*
  Behavioural far-side partner: issues start-of-frame tokens and stall
  events toward the block when the bench commands them.
  Assumes commands are driven on the rising edge of pclk.
*/
module ufc_bus_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cmd_sof,
  input  wire logic        cmd_stall,
  input  wire logic [10:0] cmd_num,
  output logic             sof_received,
  output logic      [10:0] sof_frame_number,
  output logic             stall_event,
  output logic      [3:0]  stall_endpoint
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Token generation
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sof_received     <= 1'b0;
      stall_event      <= 1'b0;
      sof_frame_number <= 11'h000;
      stall_endpoint   <= 4'h0;
    end else begin
      sof_received <= cmd_sof;
      stall_event  <= cmd_stall;
      // Number is not held between tokens, so a late capture sees garbage
      sof_frame_number <= cmd_sof ? cmd_num : ~sof_frame_number;
      stall_endpoint   <= cmd_stall ? cmd_num[3:0] : ~stall_endpoint;
    end
  end
endmodule

// [tb/ufc_top_tb.sv]
/*
  Self-checking bench for the frame, table base, configuration and
  endpoint control block. Reads are checked by a watcher against a queue.
  Assumes a zero-wait APB slave with registered read data.
*/
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); end end
module ufc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ufc_pkg::*;
  // ************
  // Declarations
  // ************
  localparam logic [7:0] ADDRS [7] = '{OFF_FRAME_NUMBER_LOW, OFF_SOF_THRESHOLD,
    OFF_TABLE_PAGE_LOW, OFF_TABLE_PAGE_MID, OFF_TABLE_PAGE_HIGH, OFF_MODULE_CONFIG,
    OFF_MODE_CONTROL};
  localparam logic [7:0] MASKS [7] = '{8'h00, 8'hFF, PAGE_LOW_MASK, 8'hFF, 8'hFF,
    CFG_MASK, MODE_MASK};
  localparam logic [7:0] TYP   [4] = '{8'h4A, 8'h2A, 8'h1A, 8'h12};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        idle_mode, sleep_mode, driving_lines, cmd_sof, cmd_stall;
  logic        sof_received, stall_event, eye_pattern_test_active, output_enable_n;
  logic        module_halted, module_suspended, low_speed_direct, nak_retry_enabled;
  logic [7:0]  paddr, lo, mid, hi;
  logic [31:0] pwdata, prdata, table_base_address, r, cfg, mode;
  logic [10:0] sof_frame_number, cmd_num;
  logic [3:0]  stall_endpoint;
  logic [15:0] rx_allowed, tx_allowed, setup_allowed, handshake_on;
  logic [32:0] exp_q [$];
  logic [32:0] head;
  logic [7:0]  ep_val [16];
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  integer      seed = 93;

  ufc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sof_received, .sof_frame_number, .idle_mode, .sleep_mode,
    .driving_lines, .stall_event, .stall_endpoint, .table_base_address,
    .eye_pattern_test_active, .output_enable_n, .module_halted, .module_suspended,
    .rx_allowed, .tx_allowed, .setup_allowed, .handshake_on, .low_speed_direct,
    .nak_retry_enabled);
  ufc_bus_partner PTR (.pclk, .presetn, .cmd_sof, .cmd_stall, .cmd_num, .sof_received,
    .sof_frame_number, .stall_event, .stall_endpoint);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // *****
  // Tasks
  // *****
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************
  // Read watcher and hang cutoff
  // ****************************
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 4000) begin
      num_errors++;
      tally_and_finish();
    end else if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      head = exp_q.size() > 0 ? exp_q.pop_front() : 33'h0;
      `CHK("apb read", head, {pslverr, prdata})
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    {presetn, psel, penable, pwrite, idle_mode, sleep_mode, driving_lines} = 7'h0;
    {cmd_sof, cmd_stall, cmd_num, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    #1;
    `CHK("oe_n in reset", 1'b1, output_enable_n)
    @(posedge pclk);
    presetn <= 1'b1;
    foreach (ADDRS[i]) rd(ADDRS[i], 32'h0);
    for (int n = 0; n < 16; n++) rd(OFF_ENDPOINT_BASE + 8'(4 * n), 32'h0);
    foreach (TYP[i]) begin
      xfer(1'b1, OFF_SOF_THRESHOLD, {24'h0, TYP[i]});
      rd(OFF_SOF_THRESHOLD, {24'h0, TYP[i]});
    end
    // Full-word writes: upper bits and the read-only frame byte must drop
    for (int k = 0; k < 2; k++) foreach (ADDRS[i]) begin
      r = $random(seed);
      xfer(1'b1, ADDRS[i], r);
      rd(ADDRS[i], {24'h0, r[7:0] & MASKS[i]});
    end
    lo = 8'hFF;
    mid = 8'($random(seed));
    hi = 8'($random(seed));
    xfer(1'b1, OFF_TABLE_PAGE_LOW, {24'hFFFFFF, lo});
    xfer(1'b1, OFF_TABLE_PAGE_MID, {24'h0, mid});
    xfer(1'b1, OFF_TABLE_PAGE_HIGH, {24'h0, hi});
    settle;
    `CHK("table base", {hi, mid, lo[7:1], 9'h000}, table_base_address)
    xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0, 1'b1);
    rd(8'h80, 32'h0, 1'b1);
    // Side-band levels walk all eight combinations three times
    for (int k = 0; k < 24; k++) begin
      cfg = $random(seed);
      mode = $random(seed);
      r = $random(seed);
      xfer(1'b1, OFF_MODULE_CONFIG, cfg);
      xfer(1'b1, OFF_MODE_CONTROL, mode);
      xfer(1'b1, OFF_ENDPOINT_BASE, r);
      @(posedge pclk);
      {idle_mode, sleep_mode, driving_lines} <= 3'(k);
      settle;
      `CHK("eye", cfg[CFG_EYE_TEST], eye_pattern_test_active)
      `CHK("oe_n", ~(cfg[CFG_OE_MONITOR] & driving_lines), output_enable_n)
      `CHK("halt", idle_mode & cfg[CFG_STOP_IN_IDLE], module_halted)
      `CHK("susp", mode[1] | (sleep_mode & cfg[CFG_AUTO_SUSPEND]), module_suspended)
      `CHK("ls direct", mode[0] & r[EP_LOW_SPEED], low_speed_direct)
      `CHK("nak retry", mode[0] & ~r[EP_RETRY_DISABLE], nak_retry_enabled)
    end
    for (int n = 0; n < 16; n++) begin
      ep_val[n] = 8'($random(seed));
      if (n < 4) ep_val[n][4:2] = {n[0], 2'b11};
      xfer(1'b1, OFF_ENDPOINT_BASE + 8'(4 * n), {24'h0, ep_val[n]});
      rd(OFF_ENDPOINT_BASE + 8'(4 * n), {24'h0, ep_val[n] & EP_MASK});
    end
    settle;
    for (int n = 0; n < 16; n++) begin
      `CHK("rx", ep_val[n][EP_RX_ENABLE], rx_allowed[n])
      `CHK("tx", ep_val[n][EP_TX_ENABLE], tx_allowed[n])
      `CHK("handshake", ep_val[n][EP_HANDSHAKE], handshake_on[n])
      if (ep_val[n][3:2] == 2'b11) `CHK("setup", ~ep_val[n][4], setup_allowed[n])
    end
    // Software clears the stall, then the bus stalls the endpoint
    xfer(1'b1, OFF_ENDPOINT_BASE + 8'h14, 32'h0C);
    rd(OFF_ENDPOINT_BASE + 8'h14, 32'h0C);
    @(posedge pclk);
    cmd_stall <= 1'b1;
    cmd_num   <= 11'd5;
    @(posedge pclk);
    cmd_stall <= 1'b0;
    settle;
    rd(OFF_ENDPOINT_BASE + 8'h14, 32'h0E);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      cmd_num <= k == 0 ? 11'h7FF : 11'h2A5;
      cmd_sof <= 1'b1;
      @(posedge pclk);
      cmd_sof <= 1'b0;
      settle;
      rd(OFF_FRAME_NUMBER_LOW, k == 0 ? 32'hFF : 32'hA5);
    end
    repeat (4) @(posedge pclk);
    `CHK("reads left", 0, exp_q.size())
    tally_and_finish();
  end
endmodule
